//--- core/crtc_pkg.sv
// Constants shared by the vertical timing and start address block.
// Assumes an indexed 8-bit register port on the character clock.
package crtc_pkg;

    // ************************************************************
    // Register indices.
    // ************************************************************
    localparam logic [7:0] IDX_OVERFLOW = 8'h07;
    localparam logic [7:0] IDX_PROTECT_LAST = 8'h07;
    localparam logic [7:0] IDX_START_HIGH = 8'h0c;
    localparam logic [7:0] IDX_START_LOW = 8'h0d;
    localparam logic [7:0] IDX_CURSOR_HIGH = 8'h0e;
    localparam logic [7:0] IDX_CURSOR_LOW = 8'h0f;
    localparam logic [7:0] IDX_VSYNC_START = 8'h10;
    localparam logic [7:0] IDX_VSYNC_END = 8'h11;
    localparam logic [7:0] IDX_VDISP_END = 8'h12;
    localparam logic [7:0] IDX_EXT_VDISP_END = 8'h31;
    localparam logic [7:0] IDX_EXT_VSYNC_START = 8'h32;
    localparam logic [7:0] IDX_START_EXT = 8'h40;
    localparam logic [7:0] IDX_START_TOP = 8'h42;
    localparam logic [7:0] IDX_IO_CONTROL = 8'h80;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int OVF_VSS_BIT9 = 7;
    localparam int OVF_VDE_BIT9 = 6;
    localparam int OVF_ALWAYS_WR = 4;
    localparam int OVF_VSS_BIT8 = 2;
    localparam int OVF_VDE_BIT8 = 1;
    localparam int VSE_PROTECT = 7;
    localparam int VSE_RSVD = 6;
    localparam int VSE_IRQ_DIS = 5;
    localparam int VSE_IRQ_CLR = 4;
    localparam int EXT_COMMIT = 7;
    localparam int EXT_RSVD = 6;
    localparam int IOC_EXT_MODE = 0;
    localparam int ST0_IRQ = 7;

    // ************************************************************
    // Reset values and widths.
    // ************************************************************
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [31:0] START_RESET = 32'h0000_0000;
    localparam logic [15:0] CURSOR_RESET = 16'h0000;
    localparam int LINE_W = 12;
    localparam logic [11:0] LINE_RESET = 12'h000;
    localparam logic [11:0] LINE_ONE = 12'h001;

endpackage

//--- core/crtc_vtiming.sv
// Vertical timing, start address and text cursor part of a CRT controller.
// Assumes the horizontal timing logic supplies same-clock line pulses and
// that host register accesses arrive already decoded as index and data.
`timescale 1ns/1ps

// Notes on behaviour
// - Standard mode start is high byte, low byte.
// - Extended start: top, ext, high, low, two zeros.
// - Extended start loads only at vsync after commit.
// - Hardware clears commit after the load.
// - Cursor location is high byte then low byte.
// - Cursor registers ignored in graphics modes.
// - IO control bit zero selects 12-bit timing.
// - Standard sync start takes overflow bits 7, 2.
// - Extended sync start takes extension nibble.
// - Sync begins on line equal to start.
// - Sync ends when low nibble matches end.
// - Protect blocks writes to indices 0-7, but overflow bit 4 stays writable.
// - Retrace start raises flag unless disabled.
// - Flag polled in status bit seven, no line.
// - Clear bit low clears and blocks the flag.
// - Standard display end takes overflow bits 6, 1.
// - Extended display end takes extension nibble.
// - Display end names the last active line.
module crtc_vtiming
    import crtc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Indexed register port.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_index,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic [7:0] status_rdata,
    // Raster position from the horizontal timing.
    input wire logic frame_start,
    input wire logic line_tick,
    input wire logic graphics_mode,
    // Display outputs.
    output logic vsync,
    output logic vdisp_active,
    output logic [31:0] start_addr,
    output logic [15:0] cursor_addr,
    output logic cursor_enable
);

    // ************************************************************
    // Register file.
    // ************************************************************
    logic [7:0] overflow_bits_reg_q, overflow_bits_reg_d;
    logic [7:0] start_addr_high_reg_q, start_addr_high_reg_d;
    logic [7:0] start_addr_low_reg_q, start_addr_low_reg_d;
    logic [7:0] cursor_loc_high_reg_q, cursor_loc_high_reg_d;
    logic [7:0] cursor_loc_low_reg_q, cursor_loc_low_reg_d;
    logic [7:0] vsync_start_reg_q, vsync_start_reg_d;
    logic [7:0] vsync_end_reg_q, vsync_end_reg_d;
    logic [7:0] vdisplay_end_reg_q, vdisplay_end_reg_d;
    logic [7:0] ext_vdisplay_end_reg_q, ext_vdisplay_end_reg_d;
    logic [7:0] ext_vsync_start_reg_q, ext_vsync_start_reg_d;
    logic [7:0] start_addr_extension_reg_q, start_addr_extension_reg_d;
    logic [7:0] start_addr_top_reg_q, start_addr_top_reg_d;
    logic io_control_reg_q, io_control_reg_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] read_mux;
    logic wr_allowed;
    logic commit_load;
    logic ext_mode;

    // ************************************************************
    // Timing and output state.
    // ************************************************************
    logic [11:0] line_q, line_d;
    logic new_line_q, new_line_d;
    logic irq_pending_q, irq_pending_d;
    logic [31:0] active_start_q, active_start_d;
    logic [31:0] start_addr_q, start_addr_d;
    logic [15:0] cursor_addr_q, cursor_addr_d;
    logic cursor_enable_q, cursor_enable_d;
    logic vdisp_active_q, vdisp_active_d;
    logic [11:0] sync_start_val;
    logic [11:0] disp_end_val;
    logic vsync_q;
    logic retrace_start;

    assign ext_mode = io_control_reg_q;
    assign commit_load = retrace_start && start_addr_extension_reg_q[EXT_COMMIT];

    // Sync start value from its low byte and the mode's upper bits.
    vert_value_compose u_sync_start (
        .low_byte(vsync_start_reg_q),
        .bit8(overflow_bits_reg_q[OVF_VSS_BIT8]),
        .bit9(overflow_bits_reg_q[OVF_VSS_BIT9]),
        .ext_high(ext_vsync_start_reg_q[3:0]),
        .ext_mode(ext_mode),
        .value(sync_start_val)
    );

    // Display end value, built the same way.
    vert_value_compose u_disp_end (
        .low_byte(vdisplay_end_reg_q),
        .bit8(overflow_bits_reg_q[OVF_VDE_BIT8]),
        .bit9(overflow_bits_reg_q[OVF_VDE_BIT9]),
        .ext_high(ext_vdisplay_end_reg_q[3:0]),
        .ext_mode(ext_mode),
        .value(disp_end_val)
    );

    // Sync pulse and the one-cycle retrace start event.
    vsync_pulse_gen u_vsync (
        .clk(clk),
        .rstn(rstn),
        .new_line(new_line_q),
        .line(line_q),
        .sync_start(sync_start_val),
        .sync_end(vsync_end_reg_q[3:0]),
        .vsync_q(vsync_q),
        .retrace_start_q(retrace_start)
    );

    // Read data mux; reserved bits read as zero.
    always_comb begin
        case (reg_index)
            IDX_OVERFLOW: read_mux = overflow_bits_reg_q;
            IDX_START_HIGH: read_mux = start_addr_high_reg_q;
            IDX_START_LOW: read_mux = start_addr_low_reg_q;
            IDX_CURSOR_HIGH: read_mux = cursor_loc_high_reg_q;
            IDX_CURSOR_LOW: read_mux = cursor_loc_low_reg_q;
            IDX_VSYNC_START: read_mux = vsync_start_reg_q;
            IDX_VSYNC_END: read_mux = vsync_end_reg_q;
            IDX_VDISP_END: read_mux = vdisplay_end_reg_q;
            IDX_EXT_VDISP_END: read_mux = ext_vdisplay_end_reg_q;
            IDX_EXT_VSYNC_START: read_mux = ext_vsync_start_reg_q;
            IDX_START_EXT: read_mux = start_addr_extension_reg_q;
            IDX_START_TOP: read_mux = start_addr_top_reg_q;
            IDX_IO_CONTROL: read_mux = {7'b000_0000, io_control_reg_q};
            default: read_mux = 8'h00;
        endcase
    end

    // Register writes. The hardware commit clear is applied first so that a
    // host write of the commit bit in the same cycle wins over it.
    always_comb begin
        overflow_bits_reg_d = overflow_bits_reg_q;
        start_addr_high_reg_d = start_addr_high_reg_q;
        start_addr_low_reg_d = start_addr_low_reg_q;
        cursor_loc_high_reg_d = cursor_loc_high_reg_q;
        cursor_loc_low_reg_d = cursor_loc_low_reg_q;
        vsync_start_reg_d = vsync_start_reg_q;
        vsync_end_reg_d = vsync_end_reg_q;
        vdisplay_end_reg_d = vdisplay_end_reg_q;
        ext_vdisplay_end_reg_d = ext_vdisplay_end_reg_q;
        ext_vsync_start_reg_d = ext_vsync_start_reg_q;
        start_addr_extension_reg_d = start_addr_extension_reg_q;
        start_addr_top_reg_d = start_addr_top_reg_q;
        io_control_reg_d = io_control_reg_q;
        rdata_d = reg_rd ? read_mux : rdata_q;
        wr_allowed = !(vsync_end_reg_q[VSE_PROTECT] && reg_index <= IDX_PROTECT_LAST);
        if (commit_load) begin
            start_addr_extension_reg_d[EXT_COMMIT] = 1'b0;
        end
        if (reg_wr) begin
            case (reg_index)
                IDX_OVERFLOW: begin
                    if (wr_allowed) begin
                        overflow_bits_reg_d = reg_wdata;
                    end else begin
                        overflow_bits_reg_d[OVF_ALWAYS_WR] = reg_wdata[OVF_ALWAYS_WR];
                    end
                end
                IDX_START_HIGH: start_addr_high_reg_d = reg_wdata;
                IDX_START_LOW: start_addr_low_reg_d = reg_wdata;
                IDX_CURSOR_HIGH: cursor_loc_high_reg_d = reg_wdata;
                IDX_CURSOR_LOW: cursor_loc_low_reg_d = reg_wdata;
                IDX_VSYNC_START: vsync_start_reg_d = reg_wdata;
                IDX_VSYNC_END: begin
                    vsync_end_reg_d = reg_wdata;
                    vsync_end_reg_d[VSE_RSVD] = 1'b0;
                end
                IDX_VDISP_END: vdisplay_end_reg_d = reg_wdata;
                IDX_EXT_VDISP_END: ext_vdisplay_end_reg_d = reg_wdata;
                IDX_EXT_VSYNC_START: ext_vsync_start_reg_d = reg_wdata;
                IDX_START_EXT: begin
                    start_addr_extension_reg_d = reg_wdata;
                    start_addr_extension_reg_d[EXT_RSVD] = 1'b0;
                end
                IDX_START_TOP: start_addr_top_reg_d = reg_wdata;
                IDX_IO_CONTROL: io_control_reg_d = reg_wdata[IOC_EXT_MODE];
                default: begin
                end
            endcase
        end
    end

    // Register file storage.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            overflow_bits_reg_q <= REG_RESET;
            start_addr_high_reg_q <= REG_RESET;
            start_addr_low_reg_q <= REG_RESET;
            cursor_loc_high_reg_q <= REG_RESET;
            cursor_loc_low_reg_q <= REG_RESET;
            vsync_start_reg_q <= REG_RESET;
            vsync_end_reg_q <= REG_RESET;
            vdisplay_end_reg_q <= REG_RESET;
            ext_vdisplay_end_reg_q <= REG_RESET;
            ext_vsync_start_reg_q <= REG_RESET;
            start_addr_extension_reg_q <= REG_RESET;
            start_addr_top_reg_q <= REG_RESET;
            io_control_reg_q <= 1'b0;
            rdata_q <= REG_RESET;
        end else begin
            overflow_bits_reg_q <= overflow_bits_reg_d;
            start_addr_high_reg_q <= start_addr_high_reg_d;
            start_addr_low_reg_q <= start_addr_low_reg_d;
            cursor_loc_high_reg_q <= cursor_loc_high_reg_d;
            cursor_loc_low_reg_q <= cursor_loc_low_reg_d;
            vsync_start_reg_q <= vsync_start_reg_d;
            vsync_end_reg_q <= vsync_end_reg_d;
            vdisplay_end_reg_q <= vdisplay_end_reg_d;
            ext_vdisplay_end_reg_q <= ext_vdisplay_end_reg_d;
            ext_vsync_start_reg_q <= ext_vsync_start_reg_d;
            start_addr_extension_reg_q <= start_addr_extension_reg_d;
            start_addr_top_reg_q <= start_addr_top_reg_d;
            io_control_reg_q <= io_control_reg_d;
            rdata_q <= rdata_d;
        end
    end

    // Line count, interrupt flag and display outputs. The active start is a
    // shadow so a half-written extended address never reaches the screen.
    always_comb begin
        line_d = line_q;
        if (frame_start) begin
            line_d = LINE_RESET;
        end else if (line_tick) begin
            line_d = line_q + LINE_ONE;
        end
        new_line_d = frame_start || line_tick;
        irq_pending_d = irq_pending_q;
        if (!vsync_end_reg_q[VSE_IRQ_CLR]) begin
            irq_pending_d = 1'b0;
        end else if (retrace_start && !vsync_end_reg_q[VSE_IRQ_DIS]) begin
            irq_pending_d = 1'b1;
        end
        active_start_d = active_start_q;
        if (commit_load) begin
            active_start_d = {start_addr_top_reg_q, start_addr_extension_reg_q[5:0],
                              start_addr_high_reg_q, start_addr_low_reg_q, 2'b00};
        end
        if (ext_mode) begin
            start_addr_d = active_start_d;
        end else begin
            start_addr_d = {16'h0000, start_addr_high_reg_q, start_addr_low_reg_q};
        end
        cursor_enable_d = !graphics_mode;
        cursor_addr_d = graphics_mode ? CURSOR_RESET
                        : {cursor_loc_high_reg_q, cursor_loc_low_reg_q};
        vdisp_active_d = (line_d <= disp_end_val);
    end

    // Timing and output registers.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            line_q <= LINE_RESET;
            new_line_q <= 1'b0;
            irq_pending_q <= 1'b0;
            active_start_q <= START_RESET;
            start_addr_q <= START_RESET;
            cursor_addr_q <= CURSOR_RESET;
            cursor_enable_q <= 1'b0;
            vdisp_active_q <= 1'b0;
        end else begin
            line_q <= line_d;
            new_line_q <= new_line_d;
            irq_pending_q <= irq_pending_d;
            active_start_q <= active_start_d;
            start_addr_q <= start_addr_d;
            cursor_addr_q <= cursor_addr_d;
            cursor_enable_q <= cursor_enable_d;
            vdisp_active_q <= vdisp_active_d;
        end
    end

    // Only a status bit is offered; there is no interrupt pin.
    assign status_rdata = {irq_pending_q, 7'b000_0000};
    assign reg_rdata = rdata_q;
    assign vsync = vsync_q;
    assign vdisp_active = vdisp_active_q;
    assign start_addr = start_addr_q;
    assign cursor_addr = cursor_addr_q;
    assign cursor_enable = cursor_enable_q;

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_std_start;
        !io_control_reg_q |=> start_addr == {16'h0000, $past(start_addr_high_reg_q),
                                            $past(start_addr_low_reg_q)};
    endproperty
    a_std_start: assert property (p_std_start) else $error("standard start wrong");

    property p_ext_load;
        commit_load && io_control_reg_q |=> start_addr == {$past(start_addr_top_reg_q),
            $past(start_addr_extension_reg_q[5:0]), $past(start_addr_high_reg_q),
            $past(start_addr_low_reg_q), 2'b00};
    endproperty
    a_ext_load: assert property (p_ext_load) else $error("extended load wrong");

    property p_ext_hold;
        io_control_reg_q && $past(io_control_reg_q) && !commit_load |=> $stable(start_addr);
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("start moved without commit");

    property p_commit_clear;
        commit_load && !(reg_wr && reg_index == IDX_START_EXT)
            |=> !start_addr_extension_reg_q[EXT_COMMIT];
    endproperty
    a_commit_clear: assert property (p_commit_clear) else $error("commit not cleared");

    property p_cursor;
        graphics_mode |=> cursor_addr == CURSOR_RESET && !cursor_enable;
    endproperty
    a_cursor: assert property (p_cursor) else $error("cursor used in graphics");

    property p_sync_begin;
        new_line_q && !vsync_q && line_q == sync_start_val |=> vsync ##1 vsync;
    endproperty
    a_sync_begin: assert property (p_sync_begin) else $error("sync did not begin");

    property p_sync_end;
        new_line_q && vsync_q && line_q[3:0] == vsync_end_reg_q[3:0] |=> !vsync;
    endproperty
    a_sync_end: assert property (p_sync_end) else $error("sync did not end");

    property p_protect;
        reg_wr && reg_index == IDX_OVERFLOW && vsync_end_reg_q[VSE_PROTECT]
            |=> overflow_bits_reg_q == {$past(overflow_bits_reg_q[7:5]),
                $past(reg_wdata[4]), $past(overflow_bits_reg_q[3:0])};
    endproperty
    a_protect: assert property (p_protect) else $error("protected write landed");

    property p_irq_set;
        retrace_start && vsync_end_reg_q[VSE_IRQ_CLR] && !vsync_end_reg_q[VSE_IRQ_DIS]
            |=> status_rdata[ST0_IRQ];
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("retrace flag not raised");

    property p_irq_clear;
        !vsync_end_reg_q[VSE_IRQ_CLR] |=> !status_rdata[ST0_IRQ];
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("retrace flag not cleared");

    property p_irq_hold;
        status_rdata[ST0_IRQ] && vsync_end_reg_q[VSE_IRQ_CLR] |=> status_rdata[ST0_IRQ];
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("retrace flag dropped");

    c_commit: cover property (commit_load && io_control_reg_q);
    c_irq: cover property (retrace_start ##1 status_rdata[ST0_IRQ]);
    c_sync: cover property (vsync ##1 !vsync);

endmodule // crtc_vtiming

//--- core/vert_value_compose.sv
// Builds a 10-bit or 12-bit vertical timing value from its register parts.
// Assumes all inputs come from registers on the same clock.
`timescale 1ns/1ps

module vert_value_compose (
    // Register parts.
    input wire logic [7:0] low_byte,
    input wire logic bit8,
    input wire logic bit9,
    input wire logic [3:0] ext_high,
    // Mode select.
    input wire logic ext_mode,
    // Result.
    output logic [11:0] value
);

    // Standard mode takes two overflow bits; extended mode a whole nibble.
    assign value = ext_mode ? {ext_high, low_byte} : {2'b00, bit9, bit8, low_byte};

endmodule // vert_value_compose

//--- core/vsync_pulse_gen.sv
// Vertical sync pulse generator driven by the scan line count.
// Assumes line is stable whenever new_line is high.
`timescale 1ns/1ps

module vsync_pulse_gen
    import crtc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Scan line position.
    input wire logic new_line,
    input wire logic [11:0] line,
    // Programmed limits.
    input wire logic [11:0] sync_start,
    input wire logic [3:0] sync_end,
    // Results.
    output logic vsync_q,
    output logic retrace_start_q
);

    logic vsync_d;
    logic retrace_start_d;

    // Decisions are taken only at line boundaries, so an end nibble equal
    // to the start nibble gives a sixteen line pulse instead of a glitch.
    always_comb begin
        vsync_d = vsync_q;
        if (new_line && vsync_q && line[3:0] == sync_end) begin
            vsync_d = 1'b0;
        end else if (new_line && !vsync_q && line == sync_start) begin
            vsync_d = 1'b1;
        end
        retrace_start_d = !vsync_q && vsync_d;
    end

    // State registers.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            vsync_q <= 1'b0;
            retrace_start_q <= 1'b0;
        end else begin
            vsync_q <= vsync_d;
            retrace_start_q <= retrace_start_d;
        end
    end

endmodule // vsync_pulse_gen

//--- test/crtc_vtiming_tb.sv
// Self-checking bench for the vertical timing and start address block.
// Assumes the raster source model drives the line pulses.
`timescale 1ns/1ps

module crtc_vtiming_tb import crtc_pkg::*;;
    logic clk, rstn, reg_wr, reg_rd, graphics_mode, run;
    logic frame_start, line_tick, vsync, vdisp_active, cursor_enable;
    logic [7:0] reg_index, reg_wdata, reg_rdata, status_rdata;
    logic [31:0] start_addr, seed, exp_start;
    logic [15:0] cursor_addr;
    logic [7:0] mdl [0:255];
    logic [7:0] idx_list [15];
    int rise_line, fall_line, err_count, n_checks, s, len, hi;

    crtc_vtiming u_crtc_vtiming (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .status_rdata(status_rdata), .frame_start(frame_start), .line_tick(line_tick),
        .graphics_mode(graphics_mode), .vsync(vsync), .vdisp_active(vdisp_active),
        .start_addr(start_addr), .cursor_addr(cursor_addr), .cursor_enable(cursor_enable));
    raster_source u_raster_source (.clk(clk), .rstn(rstn), .run(run), .frame_start(frame_start),
        .line_tick(line_tick), .vsync(vsync), .rise_line(rise_line), .fall_line(fall_line));

    // ****************************************
    // Helpers.
    // ****************************************
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // The model keeps what each index should read back, protect and masks included.
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_index <= idx;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (idx == IDX_OVERFLOW && mdl[IDX_VSYNC_END][VSE_PROTECT])
            mdl[idx][OVF_ALWAYS_WR] = d[OVF_ALWAYS_WR];
        else if (idx == IDX_IO_CONTROL)
            mdl[idx] = d & 8'h01;
        else if (idx inside {IDX_OVERFLOW, [IDX_START_HIGH:IDX_VDISP_END], IDX_EXT_VDISP_END,
                 IDX_EXT_VSYNC_START, IDX_START_EXT, IDX_START_TOP})
            mdl[idx] = d & ((idx == IDX_VSYNC_END || idx == IDX_START_EXT) ? 8'hbf : 8'hff);
    endtask

    task automatic rd(input logic [7:0] idx);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_index <= idx;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {24'h0000_00, mdl[idx]}, {24'h0000_00, reg_rdata});
    endtask

    // Waits out any pulse in progress, then one whole sync pulse, each wait bounded.
    task automatic wait_vs();
        for (int i = 0; i < 400 && vsync === 1'b1; i++) @(posedge clk);
        for (int i = 0; i < 400 && vsync !== 1'b1; i++) @(posedge clk);
        for (int i = 0; i < 400 && vsync === 1'b1; i++) @(posedge clk);
        @(posedge clk);
        #1;
    endtask

    // New start address parts, then commit; it must land only at the next sync.
    task automatic ext_load(input bit hold);
        wr(IDX_START_TOP, xs());
        wr(IDX_START_EXT, xs() & 8'h3f);
        wr(IDX_START_HIGH, xs());
        wr(IDX_START_LOW, xs());
        wr(IDX_START_EXT, mdl[IDX_START_EXT] | 8'h80);
        #1;
        if (hold) chk("start_hold", exp_start, start_addr);
        exp_start = {mdl[IDX_START_TOP], mdl[IDX_START_EXT][5:0], mdl[IDX_START_HIGH],
            mdl[IDX_START_LOW], 2'b00};
        wait_vs();
        mdl[IDX_START_EXT][EXT_COMMIT] = 1'b0;
        chk("start_addr", exp_start, start_addr);
        rd(IDX_START_EXT);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Clock and watchdog; the run needs a few thousand cycles at most.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run();
    end

    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        {rstn, reg_wr, reg_rd, graphics_mode, run} = 5'b00000;
        reg_index = 8'h00;
        reg_wdata = 8'h00;
        seed = 32'h0001_4e18;
        err_count = 0;
        n_checks = 0;
        exp_start = 32'h0000_0000;
        foreach (mdl[i]) mdl[i] = 8'h00;
        idx_list = '{8'h00, IDX_OVERFLOW, IDX_START_HIGH, IDX_START_LOW, IDX_CURSOR_HIGH,
            IDX_CURSOR_LOW, IDX_VSYNC_START, IDX_VSYNC_END, IDX_VDISP_END, IDX_EXT_VDISP_END,
            IDX_EXT_VSYNC_START, IDX_START_EXT, IDX_START_TOP, IDX_IO_CONTROL, 8'h13};
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        foreach (idx_list[k]) begin
            rd(idx_list[k]);
            wr(idx_list[k], xs());
            rd(idx_list[k]);
        end
        wr(IDX_VSYNC_END, 8'h80);
        wr(IDX_OVERFLOW, ~mdl[IDX_OVERFLOW]);
        rd(IDX_OVERFLOW);
        wr(IDX_VSYNC_END, 8'h00);
        wr(IDX_IO_CONTROL, 8'h00);
        wr(IDX_START_HIGH, xs());
        wr(IDX_START_LOW, xs());
        wr(IDX_CURSOR_HIGH, xs());
        wr(IDX_CURSOR_LOW, xs());
        repeat (2) @(posedge clk);
        #1;
        chk("start_addr", {16'h0000, mdl[IDX_START_HIGH], mdl[IDX_START_LOW]}, start_addr);
        chk("cursor", {15'h0000, 1'b1, mdl[IDX_CURSOR_HIGH], mdl[IDX_CURSOR_LOW]},
            {15'h0000, cursor_enable, cursor_addr});
        @(posedge clk);
        graphics_mode <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("cursor", 32'h0000_0000, {15'h0000, cursor_enable, cursor_addr});
        graphics_mode <= 1'b0;
        s = 4 + xs() % 27;
        len = 1 + xs() % 5;
        wr(IDX_OVERFLOW, 8'h00);
        wr(IDX_VSYNC_START, s[7:0]);
        wr(IDX_VDISP_END, 8'h0f);
        wr(IDX_VSYNC_END, 8'h10 | 8'((s + len) % 16));
        run <= 1'b1;
        wait_vs();
        chk("rise_line", s, rise_line);
        chk("fall_line", s + len, fall_line);
        chk("vdisp", 32'(s + len <= 15), {31'h0, vdisp_active});
        chk("status", 32'h0000_0080, status_rdata);
        wr(IDX_VSYNC_END, mdl[IDX_VSYNC_END] & 8'hef);
        @(posedge clk);
        #1;
        chk("status", 32'h0000_0000, status_rdata);
        wait_vs();
        chk("status", 32'h0000_0000, status_rdata);
        wr(IDX_VSYNC_END, mdl[IDX_VSYNC_END] | 8'h30);
        wait_vs();
        chk("status", 32'h0000_0000, status_rdata);
        wr(IDX_OVERFLOW, 8'h84);
        hi = 0;
        repeat (400) @(posedge clk) if (vsync !== 1'b0) hi++;
        chk("vsync_idle", 32'h0000_0000, hi);
        wr(IDX_EXT_VSYNC_START, 8'h00);
        wr(IDX_IO_CONTROL, 8'h01);
        wait_vs();
        chk("rise_line", s, rise_line);
        ext_load(1'b0);
        ext_load(1'b1);
        complete_run();
    end
endmodule // crtc_vtiming_tb

//--- test/raster_source.sv
// Raster source and sync monitor on the display side of the timing block.
// Assumes one clock; a line lasts four cycles, line 0 flagged by frame_start.
`timescale 1ns/1ps

module raster_source #(
    parameter int LINES = 40
) (
    // Clock and control.
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    // Raster pulses and sync.
    output logic frame_start,
    output logic line_tick,
    input wire logic vsync,
    // Line numbers seen at the sync edges.
    output int rise_line,
    output int fall_line
);
    int line_n;
    int phase;
    logic vs_prev;

    // Four cycles a line keep the ticks well apart, so the sync lag lands in one line.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            line_n <= 0;
            phase <= 0;
            vs_prev <= 1'b0;
            frame_start <= 1'b0;
            line_tick <= 1'b0;
            rise_line <= 0;
            fall_line <= 0;
        end else begin
            phase <= run ? (phase + 1) % 4 : phase;
            frame_start <= run && phase == 3 && line_n == LINES - 1;
            line_tick <= run && phase == 3 && line_n != LINES - 1;
            if (run && phase == 3)
                line_n <= (line_n == LINES - 1) ? 0 : line_n + 1;
            vs_prev <= vsync;
            if (vsync && !vs_prev)
                rise_line <= line_n;
            if (!vsync && vs_prev)
                fall_line <= line_n;
        end
    end
endmodule // raster_source
